// ### src/t1_clk_ctrl_pkg.sv
// package: register map, field layout and carriers of the channel clock and line control
package t1_clk_ctrl_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] CLOCK_SOURCE_IDX = 10'h100;
   localparam logic [9:0] LINE_CTRL_IDX    = 10'h101;
   localparam logic [9:0] INT_STATUS_IDX   = 10'h102;
   localparam logic [9:0] INT_MASK_IDX     = 10'h103;
   // clock source register fields
   localparam int CS_INJECT_BIT  = 7;
   localparam int CS_T1_BIT      = 6;
   localparam int CS_SYNC8K_BIT  = 5;
   localparam int CS_PROTECT_BIT = 4;
   localparam int CS_SRC_LSB     = 0;
   localparam logic [7:0] CLOCK_SOURCE_RESET = 8'h11;
   // line interface control register fields
   localparam int LC_FORCE_SIGNAL_LOSS_PATTERN_BIT = 7;
   localparam int LC_SINGLE_RAIL_BIT = 6;
   localparam int LC_LOOP_LSB      = 4;
   localparam logic [7:0] LINE_CTRL_RESET = 8'h00;
   // interrupt status and mask fields
   localparam int IRQ_CLOCK_LOSS_BIT = 5;
   localparam int IRQ_VIOLATION_BIT  = 0;
   localparam logic [7:0] IRQ_RESET  = 8'h00;
   localparam logic [7:0] IRQ_USED   = 8'h21;
   // timing source codes
   localparam logic [1:0] SRC_LOOP_A   = 2'h0;
   localparam logic [1:0] SRC_EXTERNAL = 2'h1;
   localparam logic [1:0] SRC_INTERNAL = 2'h2;
   // framer loopback codes
   localparam logic [1:0] LOOP_NONE    = 2'h0;
   localparam logic [1:0] LOOP_LOCAL   = 2'h1;
   localparam logic [1:0] LOOP_REMOTE  = 2'h2;
   localparam logic [1:0] LOOP_PAYLOAD = 2'h3;
   // effective transmit timing source
   typedef enum logic [1:0] {
      TIMING_LINE,
      TIMING_BACKPLANE,
      TIMING_PLL
   } timing_t;
   // transmit backplane pin drive: enables are low while driving
   typedef struct packed {
      logic clk_out;
      logic clk_oe_n;
      logic sync_oe_n;
      logic msync_oe_n;
   } tx_pins_t;
   // per-bit line side data
   typedef struct packed {
      logic tx_line;
      logic tx_framer_payload;
      logic rx_backplane;
   } line_bits_t;
endpackage : t1_clk_ctrl_pkg

// ### src/t1_channel_clock_line_control.sv
// one channel: transmit clock selection, pin direction, loopback and violation insertion
//
// Behaviour
// - a zero-to-one change of the inject bit places exactly one line code violation
// - carrier bit 6 selects E1 when clear, T1 when set; resets clear
// - 8 kHz alignment bit aligns transmit frames; channel zero's bit serves all channels
// - 8 kHz alignment acts only while the internal PLL times the transmitter
// - with protection on, loss of line clock recovery moves a line-timed (code 00/11) transmitter to PLL timing
// - clock-loss status bit 5 can only set while protection is enabled
// - source code 00/11 line, 01 backplane, 10 internal PLL; resets to 01
// - base rate: serial clock pin input under code 01, output otherwise
// - high-speed: clock, sync and multiframe sync pins all inputs
// - force-loss bit 7 sends the signal-loss pattern instead of traffic
// - framer loopback field bits 5:4 resets to 00 and picks the loopback
// - code 01 loops transmit backplane to receive, sends all ones to line
// - code 10 returns decoded receive line data to the line, bypassing framing
// - code 11 feeds receive payload into the transmit framer for re-framing
module t1_channel_clock_line_control
   import t1_clk_ctrl_pkg::*;
#(
   parameter bit IS_CHANNEL0 = 1'b1
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   input  wire logic        line_clock_locked,
   input  wire logic        high_speed_mode,
   input  wire logic        sync8k_from_ch0,
   input  wire logic        pll_clock_level,
   input  wire logic        line_clock_level,
   input  wire logic        tx_serial_clock_pin_in,
   input  wire logic        tx_framed_bit,
   input  wire logic        tx_backplane_bit,
   input  wire logic        rx_line_bit,
   input  wire logic        rx_framed_bit,
   input  wire logic        rx_payload_bit,
   output timing_t          tx_timing,
   output logic             t1_mode,
   output logic             frame_align_8k,
   output logic             sync8k_to_all,
   output logic             single_rail_select,
   output logic             coding_violation_inject,
   output tx_pins_t         tx_pins,
   output line_bits_t       line_bits
);
   logic [7:0] clock_source_reg;
   logic [7:0] line_interface_ctrl_reg;
   logic [7:0] int_status;
   logic [7:0] int_mask;
   logic       wr_pend;
   logic [9:0] wr_idx;
   logic       inject_prev;
   logic       lock_prev;
   logic [7:0] ev;
   logic [1:0] src_code;
   logic [1:0] loop_sel;
   logic       protect;
   logic       line_src;
   logic       addr_ok;
   timing_t    next_timing;

   assign src_code = clock_source_reg[CS_SRC_LSB +: 2];
   assign loop_sel = line_interface_ctrl_reg[LC_LOOP_LSB +: 2];
   assign protect  = clock_source_reg[CS_PROTECT_BIT];
   assign line_src = (src_code == SRC_LOOP_A) || (src_code == 2'h3);
   assign addr_ok  = hsel && hready && htrans[1];

   ////////////////////////////////////////////////////////////////////////////
   // bus slave

   // zero wait states: every transfer answers OKAY at the next edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // capture the address phase of a write; data follows one cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx  <= 10'h000;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_idx  <= haddr[11:2];
      end
   end

   // read data sampled at the address edge; unmapped words read zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ok && !hwrite) begin
         unique case (haddr[11:2])
            CLOCK_SOURCE_IDX: hrdata <= {24'h00_0000, clock_source_reg};
            LINE_CTRL_IDX:    hrdata <= {24'h00_0000, line_interface_ctrl_reg};
            INT_STATUS_IDX:   hrdata <= {24'h00_0000, int_status};
            INT_MASK_IDX:     hrdata <= {24'h00_0000, int_mask};
            default:          hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // control registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clock_source_reg        <= CLOCK_SOURCE_RESET;
         line_interface_ctrl_reg <= LINE_CTRL_RESET;
         int_mask                <= IRQ_RESET;
      end else if (wr_pend) begin
         if (wr_idx == CLOCK_SOURCE_IDX) clock_source_reg <= hwdata[7:0];
         if (wr_idx == LINE_CTRL_IDX) line_interface_ctrl_reg <= hwdata[7:0];
         if (wr_idx == INT_MASK_IDX) int_mask <= hwdata[7:0] & IRQ_USED;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // events and interrupt

   // hardware set wins over a write-one-to-clear in the same cycle
   always_comb begin
      ev = 8'h00;
      ev[IRQ_CLOCK_LOSS_BIT] = protect && lock_prev && !line_clock_locked;
      ev[IRQ_VIOLATION_BIT]  = clock_source_reg[CS_INJECT_BIT] && !inject_prev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         int_status <= IRQ_RESET;
      end else begin
         int_status <= ((wr_pend && wr_idx == INT_STATUS_IDX) ?
                        int_status & ~hwdata[7:0] : int_status) | ev;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(int_status & int_mask);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // violation insertion

   // edge of the inject bit: holding it high inserts nothing more
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         inject_prev             <= 1'b0;
         coding_violation_inject <= 1'b0;
      end else begin
         inject_prev             <= clock_source_reg[CS_INJECT_BIT];
         coding_violation_inject <= ev[IRQ_VIOLATION_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timing source

   // with protection on, loss of recovery pulls a line-timed transmitter onto the PLL until it relocks
   always_comb begin
      unique case (src_code)
         SRC_EXTERNAL: next_timing = TIMING_BACKPLANE;
         SRC_INTERNAL: next_timing = TIMING_PLL;
         default:      next_timing = (protect && !line_clock_locked) ?
                                     TIMING_PLL : TIMING_LINE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_prev      <= 1'b0;
         tx_timing      <= TIMING_BACKPLANE;
         t1_mode        <= 1'b0;
         frame_align_8k <= 1'b0;
         sync8k_to_all  <= 1'b0;
      end else begin
         lock_prev      <= line_clock_locked;
         tx_timing      <= next_timing;
         t1_mode        <= clock_source_reg[CS_T1_BIT];
         sync8k_to_all  <= IS_CHANNEL0 && clock_source_reg[CS_SYNC8K_BIT];
         // alignment only meaningful when the PLL also times the frame
         frame_align_8k <= (IS_CHANNEL0 ? clock_source_reg[CS_SYNC8K_BIT] : sync8k_from_ch0)
                           && (next_timing == TIMING_PLL);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin direction

   // sync pin direction at base rate is set here too: both sync pins follow the clock pin
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_pins <= '{clk_out: 1'b0, clk_oe_n: 1'b1, sync_oe_n: 1'b1, msync_oe_n: 1'b1};
      end else if (high_speed_mode) begin
         tx_pins <= '{clk_out: 1'b0, clk_oe_n: 1'b1, sync_oe_n: 1'b1, msync_oe_n: 1'b1};
      end else begin
         tx_pins.clk_oe_n   <= (next_timing == TIMING_BACKPLANE);
         tx_pins.sync_oe_n  <= (next_timing == TIMING_BACKPLANE);
         tx_pins.msync_oe_n <= (next_timing == TIMING_BACKPLANE);
         tx_pins.clk_out    <= (next_timing == TIMING_PLL) ? pll_clock_level
                                                            : line_clock_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // line side data paths

   // force-loss overrides any loopback on the transmit line output; the loss pattern is all zeros
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_bits          <= '0;
         single_rail_select <= 1'b0;
      end else begin
         single_rail_select <= line_interface_ctrl_reg[LC_SINGLE_RAIL_BIT];
         line_bits.rx_backplane      <= (loop_sel == LOOP_LOCAL) ?
                                        tx_backplane_bit : rx_framed_bit;
         line_bits.tx_framer_payload <= (loop_sel == LOOP_PAYLOAD) ?
                                        rx_payload_bit : tx_backplane_bit;
         if (line_interface_ctrl_reg[LC_FORCE_SIGNAL_LOSS_PATTERN_BIT]) begin
            line_bits.tx_line <= 1'b0;
         end else begin
            unique case (loop_sel)
               LOOP_LOCAL:  line_bits.tx_line <= 1'b1;
               LOOP_REMOTE: line_bits.tx_line <= rx_line_bit;
               default:     line_bits.tx_line <= tx_framed_bit;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_inject_rise;
      $rose(clock_source_reg[CS_INJECT_BIT]);
   endsequence
   sequence s_one_pulse;
      ##1 coding_violation_inject ##1 !coding_violation_inject [*3];
   endsequence

   property p_lcv_single;
      s_inject_rise |-> s_one_pulse;
   endproperty
   a_lcv_single: assert property (p_lcv_single) else $error("violation not single");

   property p_lcv_hold;
      clock_source_reg[CS_INJECT_BIT] && $past(clock_source_reg[CS_INJECT_BIT])
         |=> !coding_violation_inject;
   endproperty
   a_lcv_hold: assert property (p_lcv_hold) else $error("violation on held bit");

   property p_t1_mode;
      ##1 t1_mode == $past(clock_source_reg[CS_T1_BIT]);
   endproperty
   a_t1_mode: assert property (p_t1_mode) else $error("carrier mode wrong");

   property p_align_pll;
      frame_align_8k |-> tx_timing == TIMING_PLL;
   endproperty
   a_align_pll: assert property (p_align_pll) else $error("alignment off PLL");

   property p_fallback;
      protect && line_src && !line_clock_locked |=> tx_timing == TIMING_PLL;
   endproperty
   a_fallback: assert property (p_fallback) else $error("no PLL fallback");

   property p_loss_gate;
      $rose(int_status[IRQ_CLOCK_LOSS_BIT]) |-> $past(protect);
   endproperty
   a_loss_gate: assert property (p_loss_gate) else $error("loss status unprotected");

   property p_ext_src;
      src_code == SRC_EXTERNAL |=> tx_timing == TIMING_BACKPLANE;
   endproperty
   a_ext_src: assert property (p_ext_src) else $error("external source wrong");

   property p_base_dir;
      !high_speed_mode |=> tx_pins.clk_oe_n == (tx_timing == TIMING_BACKPLANE);
   endproperty
   a_base_dir: assert property (p_base_dir) else $error("clock pin direction");

   property p_hs_inputs;
      high_speed_mode |=> tx_pins.clk_oe_n && tx_pins.sync_oe_n && tx_pins.msync_oe_n;
   endproperty
   a_hs_inputs: assert property (p_hs_inputs) else $error("pins driven at high speed");

   property p_force_signal_loss_pattern;
      line_interface_ctrl_reg[LC_FORCE_SIGNAL_LOSS_PATTERN_BIT] |=> !line_bits.tx_line;
   endproperty
   a_force_signal_loss_pattern: assert property (p_force_signal_loss_pattern) else $error("loss pattern absent");

   property p_local_loop;
      loop_sel == LOOP_LOCAL && !line_interface_ctrl_reg[LC_FORCE_SIGNAL_LOSS_PATTERN_BIT]
         |=> line_bits.tx_line && line_bits.rx_backplane == $past(tx_backplane_bit);
   endproperty
   a_local_loop: assert property (p_local_loop) else $error("local loop wrong");

   property p_remote_loop;
      loop_sel == LOOP_REMOTE && !line_interface_ctrl_reg[LC_FORCE_SIGNAL_LOSS_PATTERN_BIT]
         |=> line_bits.tx_line == $past(rx_line_bit);
   endproperty
   a_remote_loop: assert property (p_remote_loop) else $error("remote loop wrong");

endmodule : t1_channel_clock_line_control

// ### dv/line_partner.sv
// partner model: line interface clock recovery and backplane serial clock source
module line_partner
   import t1_clk_ctrl_pkg::*;
(
   input  wire logic     hclk,
   input  wire logic     hresetn,
   input  wire logic     lock_req,
   input  wire tx_pins_t tx_pins,
   output logic          line_clock_locked,
   output logic          pll_clock_level,
   output logic          line_clock_level,
   output logic          tx_serial_clock_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic ext_clk;

   ////////////////////////////////////////////////////////////////////////////////////////
   // recovery status follows the request one edge late; recovered clock stops while lost
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         line_clock_locked <= 1'b0;
         pll_clock_level   <= 1'b0;
         line_clock_level  <= 1'b0;
         ext_clk           <= 1'b0;
      end else begin
         line_clock_locked <= lock_req;
         pll_clock_level   <= ~pll_clock_level;
         line_clock_level  <= lock_req ? ~line_clock_level : line_clock_level;
         ext_clk           <= ~ext_clk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // wire level: backplane drives only while the device leaves the pin as an input
   assign tx_serial_clock_pin_in = tx_pins.clk_oe_n ? ext_clk : tx_pins.clk_out;
endmodule : line_partner

// ### dv/t1_channel_clock_line_control_bench.sv
// testbench: register-driven checks of the channel clock and line control block
module t1_channel_clock_line_control_bench;
   import t1_clk_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] A_CS = {20'h0, CLOCK_SOURCE_IDX, 2'h0};
   localparam logic [31:0] A_LC = {20'h0, LINE_CTRL_IDX, 2'h0};
   localparam logic [31:0] A_ST = {20'h0, INT_STATUS_IDX, 2'h0};
   localparam logic [31:0] A_MK = {20'h0, INT_MASK_IDX, 2'h0};

   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, lock_req;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        line_clock_locked, high_speed_mode, sync8k_from_ch0, pll_clock_level;
   logic        line_clock_level, tx_serial_clock_pin_in, tx_framed_bit, tx_backplane_bit;
   logic        rx_line_bit, rx_framed_bit, rx_payload_bit, t1_mode, frame_align_8k;
   logic        sync8k_to_all, single_rail_select, coding_violation_inject;
   timing_t     tx_timing;
   tx_pins_t    tx_pins;
   line_bits_t  line_bits;
   int          n_fail, cmp_count, cyc, pulses;
   logic        clk_seen;
   timing_t     exp_t [4];
   logic        exp_tl [4];

   assign hready = hreadyout;

   t1_channel_clock_line_control DUT (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .irq, .line_clock_locked, .high_speed_mode,
      .sync8k_from_ch0, .pll_clock_level, .line_clock_level, .tx_serial_clock_pin_in,
      .tx_framed_bit, .tx_backplane_bit, .rx_line_bit, .rx_framed_bit, .rx_payload_bit,
      .tx_timing, .t1_mode, .frame_align_8k, .sync8k_to_all, .single_rail_select,
      .coding_violation_inject, .tx_pins, .line_bits
   );

   line_partner far_side (
      .hclk, .hresetn, .lock_req, .tx_pins, .line_clock_locked, .pll_clock_level,
      .line_clock_level, .tx_serial_clock_pin_in
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // clock, pulse counter and hang guard; ceiling far above the few hundred cycles needed
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   always @(posedge hclk) begin
      cyc++;
      if (coding_violation_inject === 1'b1) pulses++;
      if (cyc == 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // shared tasks: compare, bus cycle, settle
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // address phase held until hready, then data phase held until hready again
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk("hrdata", e, q);
      chk("hresp", 32'h0, 32'(hresp));
   endtask : rd

   // outputs trail their cause by one edge; the partner adds one more for lock changes
   task automatic settle();
      repeat (4) @(posedge hclk);
   endtask : settle

   ////////////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      exp_t  = '{TIMING_LINE, TIMING_BACKPLANE, TIMING_PLL, TIMING_LINE};
      exp_tl = '{1'b0, 1'b1, 1'b1, 1'b0};
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      lock_req = 1'b1;
      high_speed_mode = 1'b0;
      sync8k_from_ch0 = 1'b0;
      tx_framed_bit = 1'b0;
      tx_backplane_bit = 1'b0;
      rx_line_bit = 1'b1;
      rx_framed_bit = 1'b1;
      rx_payload_bit = 1'b1;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      rd(A_CS, 32'h11);
      rd(A_LC, 32'h0);
      rd(A_ST, 32'h0);
      rd(A_MK, 32'h0);
      rd(32'h500, 32'h0);
      chk("tx_timing", 32'(TIMING_BACKPLANE), 32'(tx_timing));
      // every source code: timing choice and serial clock pin direction
      for (int c = 0; c < 4; c++) begin
         wr(A_CS, 32'h10 | c);
         settle();
         chk("tx_timing", 32'(exp_t[c]), 32'(tx_timing));
         chk("clk_oe_n", 32'(c == 1), 32'(tx_pins.clk_oe_n));
      end
      @(posedge hclk);
      high_speed_mode <= 1'b1;
      settle();
      chk("oe_n", 32'h7, {tx_pins.clk_oe_n, tx_pins.sync_oe_n, tx_pins.msync_oe_n});
      high_speed_mode <= 1'b0;
      wr(A_CS, 32'h72);
      settle();
      chk("t1_mode", 32'h1, 32'(t1_mode));
      chk("frame_align_8k", 32'h1, 32'(frame_align_8k));
      chk("sync8k_to_all", 32'h1, 32'(sync8k_to_all));
      wr(A_CS, 32'h30);
      settle();
      chk("frame_align_8k", 32'h0, 32'(frame_align_8k));
      chk("t1_mode", 32'h0, 32'(t1_mode));
      // lose recovery with protection on: fall back, flag, interrupt, mask, clear
      wr(A_MK, 32'h21);
      lock_req <= 1'b0;
      settle();
      chk("tx_timing", 32'(TIMING_PLL), 32'(tx_timing));
      // the recovered clock has stopped, so a toggling pin proves the PLL drives it
      clk_seen = tx_pins.clk_out;
      @(posedge hclk);
      chk("clk_out", 32'(!clk_seen), 32'(tx_pins.clk_out));
      rd(A_ST, 32'h20);
      chk("irq", 32'h1, 32'(irq));
      wr(A_MK, 32'h0);
      settle();
      chk("irq", 32'h0, 32'(irq));
      lock_req <= 1'b1;
      settle();
      chk("tx_timing", 32'(TIMING_LINE), 32'(tx_timing));
      wr(A_ST, 32'h20);
      wr(A_MK, 32'h21);
      settle();
      chk("irq", 32'h0, 32'(irq));
      // protection off: no fallback and nothing recorded
      wr(A_CS, 32'h20);
      lock_req <= 1'b0;
      settle();
      chk("tx_timing", 32'(TIMING_LINE), 32'(tx_timing));
      // still line timed: the stopped recovered clock leaves the pin frozen
      clk_seen = tx_pins.clk_out;
      @(posedge hclk);
      chk("clk_out", 32'(clk_seen), 32'(tx_pins.clk_out));
      rd(A_ST, 32'h0);
      lock_req <= 1'b1;
      // one violation per rising write, none for a held bit
      pulses = 0;
      wr(A_CS, 32'h91);
      wr(A_CS, 32'h91);
      wr(A_CS, 32'h11);
      wr(A_CS, 32'h91);
      settle();
      chk("violations", 32'h2, 32'(pulses));
      rd(A_ST, 32'h01);
      // loopback codes, then forced loss and single rail
      for (int c = 0; c < 4; c++) begin
         wr(A_LC, 32'(c) << 4);
         settle();
         chk("tx_line", 32'(exp_tl[c]), 32'(line_bits.tx_line));
         if (c == 1) chk("rx_backplane", 32'h0, 32'(line_bits.rx_backplane));
         if (c == 3) chk("payload", 32'h1, 32'(line_bits.tx_framer_payload));
      end
      rd(A_LC, 32'h30);
      wr(A_LC, 32'hA0);
      settle();
      chk("tx_line", 32'h0, 32'(line_bits.tx_line));
      // single rail bit 6 of the line control register reaches single_rail_select one edge later
      wr(A_LC, 32'h40);
      settle();
      chk("single_rail", 32'h1, 32'(single_rail_select));
      tally_and_finish();
   end
endmodule : t1_channel_clock_line_control_bench
